/* pesr_consts.svh */
// Register indices, field positions, reset values and timing counts
`ifndef PESR_CONSTS_SVH
`define PESR_CONSTS_SVH
`define PESR_NUM_PORTS      2
`define PESR_IDX_EVENT      4'h5
`define PESR_IDX_RSVD6      4'h6
`define PESR_IDX_PAGE       4'h7
`define PESR_IDX_PSTAT      4'h8
`define PESR_IDX_PSPEED     4'h9
`define PESR_IDX_PRSVD      4'hA
`define PESR_EV_FORCERPT    0
`define PESR_EV_ARBRESET    1
`define PESR_EV_RING        2
`define PESR_EV_CABLELOST   3
`define PESR_EV_ARBTIMEOUT  4
`define PESR_EV_PORTCHANGE  5
`define PESR_EV_FASTARB     6
`define PESR_EV_MIXEDSPEED  7
`define PESR_EV_RESET       8'h08
`define PESR_PAGE_PORTSTAT  3'h0
`define PESR_PS_CHILD       4
`define PESR_PS_PEER        5
`define PESR_PS_BIAS        6
`define PESR_PS_OFF         7
`define PESR_SP_IRQON       3
`define PESR_SP_FAULT       4
`define PESR_PORT_OFF_RESET 1'h0
`define PESR_LINE_Z         2'h3
`define PESR_LINE_ONE       2'h1
`define PESR_LINE_ZERO      2'h2
`define PESR_LINE_INVALID   2'h0
`define PESR_ARB_MAX_CYCLES 16'h1388
`endif

/* pesr_pkg.sv */
// Types shared by the event and port status register bank
`default_nettype none
package pesr_pkg;
  typedef logic [7:0] pesr_byte_t;
  typedef enum logic [1:0] {
    PESR_IDLE = 2'h1,
    PESR_DATA = 2'h2
  } pesr_bus_state_t;
endpackage : pesr_pkg
`default_nettype wire

/* pesr_port_if.sv */
// Carrier between the register core and one port status slice
`default_nettype none
interface pesr_port_if;
  import pesr_pkg::*;
  logic       wrStat;
  logic       wrSpeed;
  pesr_byte_t wdata;
  logic       busReset;
  logic       treeIdActive;
  logic       selfIdActive;
  pesr_byte_t statByte;
  pesr_byte_t speedByte;
  logic       changeEvent;
  logic       irqOn;
  logic       portOff;
  modport ctrl (output wrStat, wrSpeed, wdata, busReset, treeIdActive,
                selfIdActive,
                input statByte, speedByte, changeEvent, irqOn, portOff);
  modport port (input wrStat, wrSpeed, wdata, busReset, treeIdActive,
                selfIdActive,
                output statByte, speedByte, changeEvent, irqOn, portOff);
endinterface : pesr_port_if
`default_nettype wire

/* pesr_port.sv */
// Status, disable and interrupt-enable state of one cable port
`include "pesr_consts.svh"
`default_nettype none
module pesr_port
  import pesr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  pesr_port_if.port       bus,
  input  wire logic       lineAZ,
  input  wire logic       lineAOne,
  input  wire logic       lineAZero,
  input  wire logic       lineBZ,
  input  wire logic       lineBOne,
  input  wire logic       lineBZero,
  input  wire logic       childIn,
  input  wire logic       peerIn,
  input  wire logic       biasIn,
  input  wire logic [2:0] rateIn,
  input  wire logic       suspendFault
);
  logic       portOff, irqOn, suspendErr, child, peer, bias;
  logic [2:0] rate;
  logic       next_portOff, next_irqOn, next_suspendErr, next_child;
  logic       next_peer, next_bias;
  logic [2:0] next_rate;

  // Z wins if comparators disagree
  function automatic logic [1:0] lineCode(input logic z, one, zero);
    if (z)         lineCode = `PESR_LINE_Z;
    else if (one)  lineCode = `PESR_LINE_ONE;
    else if (zero) lineCode = `PESR_LINE_ZERO;
    else           lineCode = `PESR_LINE_INVALID;
  endfunction : lineCode

  always_comb begin
    next_portOff = bus.wrStat ? bus.wdata[`PESR_PS_OFF] : portOff;
    next_irqOn   = bus.wrSpeed ? bus.wdata[`PESR_SP_IRQON] : irqOn;
    next_suspendErr = (suspendErr & ~(bus.wrSpeed &
                      bus.wdata[`PESR_SP_FAULT])) | suspendFault;
    next_child = bus.busReset ? 1'h0 :
                 (bus.treeIdActive ? childIn : child);
    next_rate  = bus.busReset ? 3'h0 :
                 (bus.selfIdActive ? rateIn : rate);
    next_peer  = peerIn;
    next_bias  = biasIn;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      portOff    <= `PESR_PORT_OFF_RESET;
      irqOn      <= 1'h0;
      suspendErr <= 1'h0;
      child      <= 1'h0;
      rate       <= 3'h0;
      peer       <= 1'h0;
      bias       <= 1'h0;
    end else begin
      portOff    <= next_portOff;
      irqOn      <= next_irqOn;
      suspendErr <= next_suspendErr;
      child      <= next_child;
      rate       <= next_rate;
      peer       <= next_peer;
      bias       <= next_bias;
    end
  end

  assign bus.changeEvent = irqOn & ((next_peer ^ peer) | (next_bias ^ bias)
                         | (next_portOff ^ portOff)
                         | (next_suspendErr ^ suspendErr));
  assign bus.statByte  = {portOff, bias, peer, child,
                          lineCode(lineBZ, lineBOne, lineBZero),
                          lineCode(lineAZ, lineAOne, lineAZero)};
  assign bus.speedByte = {3'h0, suspendErr, irqOn, rate};
  assign bus.irqOn     = irqOn;
  assign bus.portOff   = portOff;
endmodule : pesr_port
`default_nettype wire

/* pesr_regs.sv */
// Event, page select and paged port status registers on AHB-Lite
//
// The AHB-Lite register port is this design's own decision.
`include "pesr_consts.svh"
`default_nettype none
// Contract
// - Force flag reports loop, power, timeout regardless
// - Force flag makes resume interrupt regardless
// - Reset request starts short reset, self-clears
// - Loop sets ring flag; write-one clears
// - Supply fall sets lost flag; resets to one
// - Overlong arbitration state sets timeout flag
// - Enabled port bit changes set change flag
// - Forced resume sets change flag; write-one clears
// - Fast arbitration bit enables accelerated arbitration
// - Mixed speed bit selects per-packet speed codes
// - Page field selects paged register set
// - Port field selects port on status page
// - Line A code: Z, one, zero, invalid
// - Line B uses same coding as A
// - Peer bit shows attached node
// - Bias bit shows detected cable bias
// - Port off bit disables port
// - Rate field: bus reset clears, self-ID sets
// - Suspend error sets fault; write-one clears
module pesr_regs
  import pesr_pkg::*;
#(
  parameter logic [15:0] ARB_MAX_CYCLES = `PESR_ARB_MAX_CYCLES
)
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        loopSeen,
  input  wire logic        cableSupplyPresent,
  input  wire logic        arbStateEnter,
  input  wire logic        inTreeIdStart,
  input  wire logic        busReset,
  input  wire logic        treeIdActive,
  input  wire logic        selfIdActive,
  input  wire logic        shortResetDone,
  input  wire logic        linkIfActive,
  input  wire logic [1:0]  resumeStart,
  input  wire logic [1:0]  lineAZ,
  input  wire logic [1:0]  lineAOne,
  input  wire logic [1:0]  lineAZero,
  input  wire logic [1:0]  lineBZ,
  input  wire logic [1:0]  lineBOne,
  input  wire logic [1:0]  lineBZero,
  input  wire logic [1:0]  childPort,
  input  wire logic [1:0]  peerAttached,
  input  wire logic [1:0]  cableVoltageSeen,
  input  wire logic [5:0]  peerRate,
  input  wire logic [1:0]  suspendFault,
  output logic             arbitratedResetRequest,
  output logic             fastArbitrationOn,
  output logic             mixedSpeedConcatOn,
  output logic             forceStatusReport,
  output logic             statusReportReq,
  output logic             resumeIrq,
  output logic      [1:0]  portOff
);
  localparam int NP = `PESR_NUM_PORTS;

  pesr_bus_state_t busState, next_busState;
  logic [3:0]  pendIdx, next_pendIdx;
  logic        pendWrite, next_pendWrite;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;
  pesr_byte_t  evReg, next_evReg;
  logic [2:0]  pageSel, next_pageSel;
  logic [3:0]  portSel, next_portSel;
  logic        supplyPrev;
  logic [15:0] arbCount, next_arbCount;
  logic        next_statusReportReq, next_resumeIrq;
  logic        accept, wrAct, rdAct, wrEv, arbHit, reportEvt;
  pesr_byte_t  readVal, wb;
  logic [NP-1:0] portEvt, portIrqOn, wrStatV, wrSpeedV;
  pesr_byte_t  statV [NP];
  pesr_byte_t  speedV [NP];

  pesr_port_if pif [NP] ();

  // Paged port access is live only on the status page with a real port
  function automatic logic portHit(input logic [2:0] page,
                                   input logic [3:0] sel,
                                   input int unsigned p);
    portHit = (page == `PESR_PAGE_PORTSTAT) && (sel == 4'(p));
  endfunction : portHit

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : gPort
      assign pif[g].wrStat       = wrStatV[g];
      assign pif[g].wrSpeed      = wrSpeedV[g];
      assign pif[g].wdata        = wb;
      assign pif[g].busReset     = busReset;
      assign pif[g].treeIdActive = treeIdActive;
      assign pif[g].selfIdActive = selfIdActive;
      assign statV[g]     = pif[g].statByte;
      assign speedV[g]    = pif[g].speedByte;
      assign portEvt[g]   = pif[g].changeEvent;
      assign portIrqOn[g] = pif[g].irqOn;
      assign portOff[g]   = pif[g].portOff;
      assign wrStatV[g]  = wrAct && pendIdx == `PESR_IDX_PSTAT
                           && portHit(pageSel, portSel, g);
      assign wrSpeedV[g] = wrAct && pendIdx == `PESR_IDX_PSPEED
                           && portHit(pageSel, portSel, g);
      pesr_port uPort (
        .clock        (clock),
        .arst_n       (arst_n),
        .bus          (pif[g]),
        .lineAZ       (lineAZ[g]),
        .lineAOne     (lineAOne[g]),
        .lineAZero    (lineAZero[g]),
        .lineBZ       (lineBZ[g]),
        .lineBOne     (lineBOne[g]),
        .lineBZero    (lineBZero[g]),
        .childIn      (childPort[g]),
        .peerIn       (peerAttached[g]),
        .biasIn       (cableVoltageSeen[g]),
        .rateIn       (peerRate[3*g +: 3]),
        .suspendFault (suspendFault[g])
      );
    end
  endgenerate

  // One wait state per transfer so a read never races a pending write
  assign accept = hsel && htrans[1] && hready;
  assign wrAct  = (busState == PESR_DATA) && pendWrite;
  assign rdAct  = (busState == PESR_DATA) && !pendWrite;
  assign wb     = hwdata[7:0];
  assign wrEv   = wrAct && pendIdx == `PESR_IDX_EVENT;

  always_comb begin
    next_busState  = busState;
    next_pendIdx   = pendIdx;
    next_pendWrite = pendWrite;
    next_hreadyout = hreadyout;
    unique case (busState)
      PESR_IDLE: begin
        if (accept) begin
          next_busState  = PESR_DATA;
          next_pendIdx   = haddr[5:2];
          next_pendWrite = hwrite;
          next_hreadyout = 1'h0;
        end
      end
      PESR_DATA: begin
        next_busState  = PESR_IDLE;
        next_hreadyout = 1'h1;
      end
      default: begin
        next_busState  = PESR_IDLE;
        next_hreadyout = 1'h1;
      end
    endcase
  end

  // Read data: unmapped, reserved and unpopulated pages read zero
  always_comb begin
    readVal = 8'h00;
    unique case (pendIdx)
      `PESR_IDX_EVENT: readVal = evReg;
      `PESR_IDX_PAGE:  readVal = {portSel, 1'h0, pageSel};
      `PESR_IDX_PSTAT, `PESR_IDX_PSPEED: begin
        for (int p = 0; p < NP; p++) begin
          if (portHit(pageSel, portSel, p)) begin
            readVal = (pendIdx == `PESR_IDX_PSTAT) ? statV[p] : speedV[p];
          end
        end
      end
      default: readVal = 8'h00;
    endcase
    next_hrdata = rdAct ? {24'h000000, readVal} : hrdata;
  end

  // Arbitration dwell timer; tree-ID start is exempt
  always_comb begin
    if (arbStateEnter || inTreeIdStart) begin
      next_arbCount = 16'h0000;
    end else if (arbCount == ARB_MAX_CYCLES) begin
      next_arbCount = arbCount;
    end else begin
      next_arbCount = arbCount + 16'h0001;
    end
    arbHit = (next_arbCount == ARB_MAX_CYCLES)
             && (arbCount != ARB_MAX_CYCLES);
  end

  // Sticky flags: a set in the clearing cycle wins
  always_comb begin
    next_evReg = evReg;
    next_pageSel = pageSel;
    next_portSel = portSel;
    if (wrEv) begin
      next_evReg[`PESR_EV_FORCERPT]   = wb[`PESR_EV_FORCERPT];
      next_evReg[`PESR_EV_FASTARB]    = wb[`PESR_EV_FASTARB];
      next_evReg[`PESR_EV_MIXEDSPEED] = wb[`PESR_EV_MIXEDSPEED];
    end
    if (wrAct && pendIdx == `PESR_IDX_PAGE) begin
      next_pageSel = wb[2:0];
      next_portSel = wb[7:4];
    end
    next_evReg[`PESR_EV_ARBRESET] = (evReg[`PESR_EV_ARBRESET]
      & ~shortResetDone) | (wrEv & wb[`PESR_EV_ARBRESET]);
    next_evReg[`PESR_EV_RING] = (evReg[`PESR_EV_RING]
      & ~(wrEv & wb[`PESR_EV_RING])) | loopSeen;
    next_evReg[`PESR_EV_CABLELOST] = (evReg[`PESR_EV_CABLELOST]
      & ~(wrEv & wb[`PESR_EV_CABLELOST]))
      | (supplyPrev & ~cableSupplyPresent);
    next_evReg[`PESR_EV_ARBTIMEOUT] = (evReg[`PESR_EV_ARBTIMEOUT]
      & ~(wrEv & wb[`PESR_EV_ARBTIMEOUT])) | arbHit;
    next_evReg[`PESR_EV_PORTCHANGE] = (evReg[`PESR_EV_PORTCHANGE]
      & ~(wrEv & wb[`PESR_EV_PORTCHANGE])) | (|portEvt)
      | (evReg[`PESR_EV_FORCERPT] & (|resumeStart));
    reportEvt = loopSeen | (supplyPrev & ~cableSupplyPresent) | arbHit;
    next_statusReportReq = reportEvt
      & (linkIfActive | evReg[`PESR_EV_FORCERPT]);
    next_resumeIrq = |(resumeStart
      & (portIrqOn | {NP{evReg[`PESR_EV_FORCERPT]}}));
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busState        <= PESR_IDLE;
      pendIdx         <= 4'h0;
      pendWrite       <= 1'h0;
      hrdata          <= 32'h00000000;
      hreadyout       <= 1'h1;
      hresp           <= 1'h0;
      evReg           <= `PESR_EV_RESET;
      pageSel         <= 3'h0;
      portSel         <= 4'h0;
      supplyPrev      <= 1'h1;
      arbCount        <= 16'h0000;
      statusReportReq <= 1'h0;
      resumeIrq       <= 1'h0;
    end else begin
      busState        <= next_busState;
      pendIdx         <= next_pendIdx;
      pendWrite       <= next_pendWrite;
      hrdata          <= next_hrdata;
      hreadyout       <= next_hreadyout;
      hresp           <= 1'h0;
      evReg           <= next_evReg;
      pageSel         <= next_pageSel;
      portSel         <= next_portSel;
      supplyPrev      <= cableSupplyPresent;
      arbCount        <= next_arbCount;
      statusReportReq <= next_statusReportReq;
      resumeIrq       <= next_resumeIrq;
    end
  end

  assign arbitratedResetRequest = evReg[`PESR_EV_ARBRESET];
  assign fastArbitrationOn      = evReg[`PESR_EV_FASTARB];
  assign mixedSpeedConcatOn     = evReg[`PESR_EV_MIXEDSPEED];
  assign forceStatusReport      = evReg[`PESR_EV_FORCERPT];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  a_ready_wait: assert property (accept |=> !hreadyout ##1 hreadyout)
    else $error("wait state not one cycle");
  a_force_report: assert property (
    loopSeen && forceStatusReport |=> statusReportReq)
    else $error("forced status report missing");
  a_resume_irq: assert property (
    (|resumeStart) && forceStatusReport |=> resumeIrq)
    else $error("forced resume interrupt missing");
  a_reset_clear: assert property (
    arbitratedResetRequest && shortResetDone
    && !(wrEv && wb[`PESR_EV_ARBRESET]) |=> !arbitratedResetRequest)
    else $error("short reset request did not clear");
  a_ring_w1c: assert property (
    wrEv && wb[`PESR_EV_RING] && !loopSeen |=> !evReg[`PESR_EV_RING])
    else $error("ring flag not cleared");
  a_ring_set: assert property (
    loopSeen |=> evReg[`PESR_EV_RING] ##1 $stable(evReg[`PESR_EV_RING])
    || $past(wrEv))
    else $error("ring flag lost");
  a_supply_fall: assert property (
    $fell(cableSupplyPresent) |=> evReg[`PESR_EV_CABLELOST])
    else $error("supply loss not flagged");
  a_arb_timeout: assert property (
    arbHit |=> evReg[`PESR_EV_ARBTIMEOUT])
    else $error("arbitration timeout not flagged");
  a_port_change: assert property (
    |portEvt |=> evReg[`PESR_EV_PORTCHANGE])
    else $error("port change not flagged");
  a_resume_flag: assert property (
    (|resumeStart) && forceStatusReport |=> evReg[`PESR_EV_PORTCHANGE])
    else $error("resume did not set change flag");
  a_fast_arb: assert property (
    wrEv |=> fastArbitrationOn == $past(wb[`PESR_EV_FASTARB]))
    else $error("fast arbitration bit not written");
  a_page_zero: assert property (
    rdAct && pendIdx == `PESR_IDX_PSTAT && pageSel != `PESR_PAGE_PORTSTAT
    |=> hrdata == 32'h00000000)
    else $error("other page read not zero");
  a_rsvd_read: assert property (
    rdAct && pendIdx == `PESR_IDX_RSVD6 |=> hrdata == 32'h00000000)
    else $error("reserved register read not zero");
  a_keep_flag: assert property (
    wrEv && !wb[`PESR_EV_RING] && evReg[`PESR_EV_RING]
    |=> evReg[`PESR_EV_RING])
    else $error("writing zero cleared flag");
  a_page_write: assert property (
    wrAct && pendIdx == `PESR_IDX_PAGE
    |=> {portSel, pageSel} == {$past(wb[7:4]), $past(wb[2:0])})
    else $error("page select not written");
  a_link_report: assert property (
    reportEvt && linkIfActive |=> statusReportReq)
    else $error("status report missing");
  a_timeout_w1c: assert property (
    wrEv && wb[`PESR_EV_ARBTIMEOUT] && !arbHit
    |=> !evReg[`PESR_EV_ARBTIMEOUT])
    else $error("timeout flag kept");
  a_lost_w1c: assert property (
    wrEv && wb[`PESR_EV_CABLELOST] && !(supplyPrev && !cableSupplyPresent)
    |=> !evReg[`PESR_EV_CABLELOST])
    else $error("lost flag kept");
  a_port_off: assert property (
    wrStatV[0] |=> portOff[0] == $past(wb[`PESR_PS_OFF]))
    else $error("port disable not written");

  c_short_reset: cover property (
    arbitratedResetRequest ##[1:20] !arbitratedResetRequest);
  c_resume_irq: cover property (resumeIrq);
  c_port_read: cover property (
    rdAct && pendIdx == `PESR_IDX_PSTAT && portSel == 4'h1);
  c_timeout: cover property (arbHit);
  c_link_report: cover property (statusReportReq && !forceStatusReport);
endmodule : pesr_regs
`default_nettype wire

/* pesr_link_model.sv */
// Link controller stand-in that counts status reports and resume interrupts
`default_nettype none
module pesr_link_model (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       statusReportReq,
  input  wire logic       resumeIrq,
  output var  logic [7:0] reportCount,
  output var  logic [7:0] irqCount
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulses last one cycle, so each high edge is one event
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reportCount <= 8'h00;
      irqCount    <= 8'h00;
    end else begin
      if (statusReportReq) reportCount <= reportCount + 8'h01;
      if (resumeIrq) irqCount <= irqCount + 8'h01;
    end
  end
endmodule : pesr_link_model
`default_nettype wire

/* phy_event_and_port_status_regs_test.sv */
// Self-checking bench for the event and port status register bank
`include "pesr_consts.svh"
`default_nettype none
module phy_event_and_port_status_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ARB = 20;
  logic        clock, arst_n, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr, reportCount, irqCount, rv;
  logic [1:0]  htrans, resumeStart, lineAZ, lineAOne, lineAZero;
  logic [1:0]  lineBZ, lineBOne, lineBZero, childPort, peerAttached;
  logic [1:0]  cableVoltageSeen, suspendFault, portOff;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic [5:0]  peerRate;
  logic        loopSeen, cableSupplyPresent, arbStateEnter, inTreeIdStart;
  logic        busReset, treeIdActive, selfIdActive, shortResetDone;
  logic        linkIfActive, arbitratedResetRequest, fastArbitrationOn;
  logic        mixedSpeedConcatOn, forceStatusReport, statusReportReq;
  logic        resumeIrq;
  logic [1:0]  lineCode [4];
  int          failures, tests_run, j;
  string       cur;

  pesr_regs #(.ARB_MAX_CYCLES(16'(ARB))) dut_u (
    .clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .loopSeen(loopSeen),
    .cableSupplyPresent(cableSupplyPresent), .arbStateEnter(arbStateEnter),
    .inTreeIdStart(inTreeIdStart), .busReset(busReset),
    .treeIdActive(treeIdActive), .selfIdActive(selfIdActive),
    .shortResetDone(shortResetDone), .linkIfActive(linkIfActive),
    .resumeStart(resumeStart), .lineAZ(lineAZ), .lineAOne(lineAOne),
    .lineAZero(lineAZero), .lineBZ(lineBZ), .lineBOne(lineBOne),
    .lineBZero(lineBZero), .childPort(childPort),
    .peerAttached(peerAttached), .cableVoltageSeen(cableVoltageSeen),
    .peerRate(peerRate), .suspendFault(suspendFault),
    .arbitratedResetRequest(arbitratedResetRequest),
    .fastArbitrationOn(fastArbitrationOn),
    .mixedSpeedConcatOn(mixedSpeedConcatOn),
    .forceStatusReport(forceStatusReport),
    .statusReportReq(statusReportReq), .resumeIrq(resumeIrq),
    .portOff(portOff)
  );

  pesr_link_model link_u (
    .clock(clock), .arst_n(arst_n), .statusReportReq(statusReportReq),
    .resumeIrq(resumeIrq), .reportCount(reportCount), .irqCount(irqCount)
  );

  always #20 clock = ~clock;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, cur, got, exp);
    end
  endtask : chk

  // Bounded so a stuck slave ends in a mismatch, not a hang
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      final_report();
    end
  endtask : waitReady

  task automatic xfer(input logic w, input logic [3:0] idx,
                      input logic [7:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {2'h0, idx, 2'h0};
    waitReady();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    waitReady();
    rv = hrdata[7:0];
  endtask : xfer

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic rc(input logic [3:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    chk(rv, e);
  endtask : rc

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (6000) @(posedge clock);
    failures++;
    final_report();
  end

  initial begin
    clock = 0; arst_n = 0; hsel = 0; hwrite = 0; haddr = 8'h00;
    htrans = 2'h0; hsize = 3'h2; hwdata = 32'h00000000;
    loopSeen = 0; cableSupplyPresent = 1; arbStateEnter = 0;
    inTreeIdStart = 1; busReset = 0; treeIdActive = 0; selfIdActive = 0;
    shortResetDone = 0; linkIfActive = 0; resumeStart = 2'h0;
    lineAZ = 2'h2; lineAOne = 2'h0; lineAZero = 2'h0; lineBZ = 2'h0;
    lineBOne = 2'h0; lineBZero = 2'h0; childPort = 2'h0;
    peerAttached = 2'h0; cableVoltageSeen = 2'h0; peerRate = 6'h00;
    suspendFault = 2'h0; failures = 0; tests_run = 0;
    lineCode = '{2'h3, 2'h1, 2'h2, 2'h0};
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    cur = "reset";
    rc(`PESR_IDX_EVENT, 8'h08);
    rc(`PESR_IDX_RSVD6, 8'h00);
    rc(`PESR_IDX_PRSVD, 8'h00);
    rc(4'h0, 8'h00);
    rc(`PESR_IDX_PAGE, 8'h00);
    rc(`PESR_IDX_PSPEED, 8'h00);
    chk({6'h00, portOff}, 8'h00);
    $display("test %s done", cur);
    cur = "flags";
    wr(`PESR_IDX_EVENT, 8'h00);
    rc(`PESR_IDX_EVENT, 8'h08);
    wr(`PESR_IDX_EVENT, 8'h08);
    rc(`PESR_IDX_EVENT, 8'h00);
    @(posedge clock) cableSupplyPresent <= 1'b0;
    rc(`PESR_IDX_EVENT, 8'h08);
    wr(`PESR_IDX_EVENT, 8'h08);
    @(posedge clock) loopSeen <= 1'b1;
    @(posedge clock) loopSeen <= 1'b0;
    rc(`PESR_IDX_EVENT, 8'h04);
    chk(reportCount, 8'h00);
    wr(`PESR_IDX_EVENT, 8'h05);
    @(posedge clock) loopSeen <= 1'b1;
    @(posedge clock) loopSeen <= 1'b0;
    rc(`PESR_IDX_EVENT, 8'h05);
    chk(reportCount, 8'h01);
    wr(`PESR_IDX_EVENT, 8'h05);
    wr(`PESR_IDX_EVENT, 8'h03);
    chk({7'h00, arbitratedResetRequest}, 8'h01);
    rc(`PESR_IDX_EVENT, 8'h03);
    @(posedge clock) shortResetDone <= 1'b1;
    @(posedge clock) shortResetDone <= 1'b0;
    @(posedge clock);
    chk({7'h00, arbitratedResetRequest}, 8'h00);
    wr(`PESR_IDX_EVENT, 8'hC1);
    chk({5'h00, mixedSpeedConcatOn, fastArbitrationOn, forceStatusReport},
        8'h07);
    rc(`PESR_IDX_EVENT, 8'hC1);
    wr(`PESR_IDX_EVENT, 8'h01);
    chk({7'h00, fastArbitrationOn}, 8'h00);
    $display("test %s done", cur);
    cur = "timeout";
    inTreeIdStart <= 1'b0;
    repeat (ARB / 2) @(posedge clock);
    arbStateEnter <= 1'b1;
    @(posedge clock) arbStateEnter <= 1'b0;
    repeat (ARB / 2) @(posedge clock);
    rc(`PESR_IDX_EVENT, 8'h01);
    repeat (ARB) @(posedge clock);
    rc(`PESR_IDX_EVENT, 8'h11);
    chk(reportCount, 8'h02);
    inTreeIdStart <= 1'b1;
    wr(`PESR_IDX_EVENT, 8'h10);
    rc(`PESR_IDX_EVENT, 8'h00);
    $display("test %s done", cur);
    cur = "lines";
    for (int i = 0; i < 4; i++) begin
      j = (i + 1) % 4;
      lineAZ    <= {1'b1, i == 0};
      lineAOne  <= {1'b0, i == 1};
      lineAZero <= {1'b0, i == 2};
      lineBZ    <= {1'b0, j == 0};
      lineBOne  <= {1'b0, j == 1};
      lineBZero <= {1'b0, j == 2};
      rc(`PESR_IDX_PSTAT, {4'h0, lineCode[j], lineCode[i]});
    end
    lineAZ <= 2'h2; lineAOne <= 2'h0; lineAZero <= 2'h0;
    lineBZ <= 2'h0; lineBOne <= 2'h0; lineBZero <= 2'h0;
    peerAttached <= 2'h2; cableVoltageSeen <= 2'h2;
    wr(`PESR_IDX_PAGE, 8'h18);
    rc(`PESR_IDX_PAGE, 8'h10);
    rc(`PESR_IDX_PSTAT, 8'h63);
    wr(`PESR_IDX_PAGE, 8'h11);
    rc(`PESR_IDX_PSTAT, 8'h00);
    wr(`PESR_IDX_PAGE, 8'h20);
    rc(`PESR_IDX_PSTAT, 8'h00);
    wr(`PESR_IDX_PAGE, 8'h00);
    rc(`PESR_IDX_PSTAT, 8'h00);
    $display("test %s done", cur);
    cur = "tree";
    childPort <= 2'h1; treeIdActive <= 1'b1;
    peerRate <= 6'h02; selfIdActive <= 1'b1;
    repeat (2) @(posedge clock);
    treeIdActive <= 1'b0; selfIdActive <= 1'b0;
    @(posedge clock) childPort <= 2'h0;
    peerRate <= 6'h00;
    rc(`PESR_IDX_PSTAT, 8'h10);
    rc(`PESR_IDX_PSPEED, 8'h02);
    @(posedge clock) busReset <= 1'b1;
    @(posedge clock) busReset <= 1'b0;
    rc(`PESR_IDX_PSTAT, 8'h00);
    rc(`PESR_IDX_PSPEED, 8'h00);
    $display("test %s done", cur);
    cur = "ports";
    peerAttached <= 2'h3;
    rc(`PESR_IDX_EVENT, 8'h00);
    wr(`PESR_IDX_PSPEED, 8'h08);
    rc(`PESR_IDX_PSPEED, 8'h08);
    peerAttached <= 2'h2;
    rc(`PESR_IDX_EVENT, 8'h20);
    wr(`PESR_IDX_EVENT, 8'h20);
    rc(`PESR_IDX_EVENT, 8'h00);
    wr(`PESR_IDX_PSTAT, 8'h80);
    chk({6'h00, portOff}, 8'h01);
    rc(`PESR_IDX_PSTAT, 8'h80);
    rc(`PESR_IDX_EVENT, 8'h20);
    wr(`PESR_IDX_EVENT, 8'h20);
    @(posedge clock) suspendFault <= 2'h1;
    @(posedge clock) suspendFault <= 2'h0;
    rc(`PESR_IDX_PSPEED, 8'h18);
    wr(`PESR_IDX_PSPEED, 8'h08);
    rc(`PESR_IDX_PSPEED, 8'h18);
    wr(`PESR_IDX_PSPEED, 8'h18);
    rc(`PESR_IDX_PSPEED, 8'h08);
    rc(`PESR_IDX_EVENT, 8'h20);
    wr(`PESR_IDX_EVENT, 8'h20);
    $display("test %s done", cur);
    cur = "resume";
    @(posedge clock) resumeStart <= 2'h2;
    @(posedge clock) resumeStart <= 2'h0;
    rc(`PESR_IDX_EVENT, 8'h00);
    chk(irqCount, 8'h00);
    wr(`PESR_IDX_EVENT, 8'h01);
    @(posedge clock) resumeStart <= 2'h2;
    @(posedge clock) resumeStart <= 2'h0;
    rc(`PESR_IDX_EVENT, 8'h21);
    chk(irqCount, 8'h01);
    wr(`PESR_IDX_EVENT, 8'h20);
    linkIfActive <= 1'b1;
    @(posedge clock) loopSeen <= 1'b1;
    @(posedge clock) loopSeen <= 1'b0;
    wr(`PESR_IDX_EVENT, 8'h00);
    rc(`PESR_IDX_EVENT, 8'h04);
    chk(reportCount, 8'h03);
    chk({7'h00, hresp}, 8'h00);
    $display("test %s done", cur);
    cur = "hwreset";
    arst_n <= 1'b0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    rc(`PESR_IDX_EVENT, 8'h08);
    rc(`PESR_IDX_PSPEED, 8'h00);
    chk({6'h00, portOff}, 8'h00);
    $display("test %s done", cur);
    final_report();
  end
endmodule : phy_event_and_port_status_regs_test
`default_nettype wire
